// ### dv/fme_host_model.sv
// Host processor model driving the register port with single-byte strobes
`timescale 1ns/10ps
`default_nettype none
module fme_host_model
  import fme_pkg::*;
(
  input wire logic clk_in,
  input wire logic [7:0] rdata_in,
  input wire logic rvalid_in,
  output var fme_pkg::fme_reg_req_t req_out
);
  initial req_out = '0;

  // Released address and data show the inverse, never a stale copy
  task automatic wr_reg(input logic [7:0] addr, input logic [7:0] data);
    @(posedge clk_in);
    #1 req_out = {1'h1, 1'h0, addr, data};
    @(posedge clk_in);
    #1 req_out = {1'h0, 1'h0, ~addr, ~data};
  endtask

  // Answer is sampled in the single cycle that follows the taking edge
  task automatic rd_reg(input logic [7:0] addr, output logic [7:0] data, output logic ok);
    @(posedge clk_in);
    #1 req_out = {1'h0, 1'h1, addr, 8'h00};
    @(posedge clk_in);
    #1 req_out = {1'h0, 1'h0, ~addr, 8'hFF};
    ok = rvalid_in;
    data = rdata_in;
  endtask
endmodule
`default_nettype wire

// ### dv/tb.sv
// Self-checking bench for the freefall/motion event detector
`timescale 1ns/10ps
`default_nettype none
module tb;
  import fme_pkg::*;
  logic core_clk = 1'h0;
  logic arst_n = 1'h0;
  logic sample_valid = 1'h0;
  fme_accel_t accel = '0;
  fme_reg_req_t req;
  logic [7:0] rdata;
  logic rvalid;
  logic evt;
  logic standby = 1'h0;
  int num_errors = 0;
  int check_count = 0;

  always #12.5 core_clk = ~core_clk;

  fme_detector i_dut (.core_clk_in(core_clk), .arst_n_in(arst_n), .standby_in(standby),
    .sample_valid_in(sample_valid), .accel_in(accel), .reg_req_in(req),
    .reg_rdata_out(rdata), .reg_rvalid_out(rvalid), .event_active_out(evt));
  fme_host_model i_host (.clk_in(core_clk), .rdata_in(rdata), .rvalid_in(rvalid),
    .req_out(req));

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask

  task automatic rchk(input logic [7:0] addr, input logic [7:0] exp);
    logic [7:0] d;
    logic ok;
    i_host.rd_reg(addr, d, ok);
    chk("read valid", 8'h01, {7'h00, ok});
    chk($sformatf("register %h", addr), exp, d);
  endtask

  task automatic rst(input int cycles);
    @(posedge core_clk);
    #1 arst_n = 1'h0;
    repeat (cycles) @(posedge core_clk);
    #1 arst_n = 1'h1;
  endtask

  // Fresh reset between scenarios, since mode changes keep old state
  task automatic setup(input logic [7:0] c, input logic [7:0] t, input logic [7:0] n);
    rst(2);
    i_host.wr_reg(FME_ADDR_CFG, c);
    i_host.wr_reg(FME_ADDR_THS, t);
    i_host.wr_reg(FME_ADDR_CNT, n);
  endtask

  // One sample tick, then the event flag after that edge
  task automatic smp(input logic [7:0] x, input logic [7:0] y, input logic [7:0] z,
                     input logic exp_evt);
    @(posedge core_clk);
    #1 sample_valid = 1'h1;
    accel = {z, y, x};
    @(posedge core_clk);
    #1 sample_valid = 1'h0;
    accel = ~accel;
    chk("event active", {7'h00, exp_evt}, {7'h00, evt});
  endtask

  task automatic t_regs();
    rchk(FME_ADDR_CFG, 8'h00);
    rchk(FME_ADDR_SRC, 8'h00);
    rchk(FME_ADDR_THS, 8'h00);
    rchk(FME_ADDR_CNT, 8'h00);
    rchk(8'h20, 8'h00);
    i_host.wr_reg(FME_ADDR_CFG, 8'hFF);
    rchk(FME_ADDR_CFG, 8'hF8);
    i_host.wr_reg(FME_ADDR_SRC, 8'hFF);
    rchk(FME_ADDR_SRC, 8'h00);
    i_host.wr_reg(FME_ADDR_THS, 8'hA5);
    rchk(FME_ADDR_THS, 8'hA5);
    i_host.wr_reg(FME_ADDR_CNT, 8'h3C);
    rchk(FME_ADDR_CNT, 8'h3C);
  endtask

  task automatic t_enables();
    setup(8'h00, 8'h05, 8'h00);
    smp(8'h00, 8'h00, 8'h00, 1'h0);
    setup(8'h48, 8'h05, 8'h00);
    smp(8'h00, 8'h7F, 8'h80, 1'h0);
    rchk(FME_ADDR_SRC, 8'h00);
  endtask

  task automatic t_ff_dec();
    setup(8'h38, 8'h05, 8'h02);
    smp(8'h05, 8'hFB, 8'h00, 1'h0);
    smp(8'h05, 8'hFB, 8'h00, 1'h1);
    rchk(FME_ADDR_SRC, 8'h80);
    chk("event after read", 8'h01, {7'h00, evt});
    smp(8'h06, 8'h00, 8'h00, 1'h1);
    smp(8'h06, 8'h00, 8'h00, 1'h0);
    rchk(FME_ADDR_SRC, 8'h02);
  endtask

  task automatic t_ff_clr();
    setup(8'h38, 8'h85, 8'h02);
    smp(8'h00, 8'h00, 8'h00, 1'h0);
    smp(8'h00, 8'h00, 8'h00, 1'h1);
    smp(8'h00, 8'hFA, 8'h00, 1'h0);
    smp(8'h00, 8'h00, 8'h00, 1'h0);
    smp(8'h00, 8'h00, 8'h00, 1'h1);
  endtask

  task automatic t_mo_unl();
    setup(8'h78, 8'h85, 8'h00);
    smp(8'hFA, 8'h00, 8'h00, 1'h1);
    rchk(FME_ADDR_SRC, 8'h83);
    rchk(FME_ADDR_SRC, 8'h83);
    chk("event after read", 8'h01, {7'h00, evt});
    smp(8'h05, 8'h00, 8'h00, 1'h0);
    rchk(FME_ADDR_SRC, 8'h00);
  endtask

  task automatic t_mo_lat();
    setup(8'hF8, 8'h05, 8'h02);
    smp(8'h00, 8'h00, 8'h07, 1'h0);
    smp(8'h00, 8'h00, 8'h07, 1'h1);
    smp(8'h00, 8'hF7, 8'h00, 1'h1);
    rchk(FME_ADDR_SRC, 8'hA0);
    rchk(FME_ADDR_SRC, 8'h00);
    chk("event after read", 8'h00, {7'h00, evt});
    smp(8'h00, 8'h00, 8'h07, 1'h0);
    smp(8'h00, 8'h00, 8'h07, 1'h1);
  endtask

  task automatic t_ff_lat();
    setup(8'hB8, 8'h05, 8'h02);
    smp(8'h00, 8'h00, 8'h00, 1'h0);
    smp(8'h00, 8'h00, 8'h00, 1'h1);
    smp(8'h06, 8'h00, 8'h00, 1'h1);
    rchk(FME_ADDR_SRC, 8'h80);
    rchk(FME_ADDR_SRC, 8'h00);
    chk("event after read", 8'h00, {7'h00, evt});
    smp(8'h00, 8'h00, 8'h00, 1'h0);
    smp(8'h00, 8'h00, 8'h00, 1'h1);
  endtask

  // Standby wipes the standing event and the stored axis flags
  task automatic t_standby();
    setup(8'h78, 8'h05, 8'h00);
    smp(8'hFA, 8'h00, 8'h00, 1'h1);
    @(posedge core_clk);
    #1 standby = 1'h1;
    @(posedge core_clk);
    #1 standby = 1'h0;
    chk("event after standby", 8'h00, {7'h00, evt});
    rchk(FME_ADDR_SRC, 8'h00);
  endtask

  task automatic tally_and_finish();
    $display("checks %0d, errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  initial begin
    rst(6);
    t_regs();
    t_enables();
    t_ff_dec();
    t_ff_clr();
    t_mo_unl();
    t_mo_lat();
    t_ff_lat();
    t_standby();
    tally_and_finish();
  end
endmodule
`default_nettype wire

// ### pkg/fme_pkg.sv
// Constants and types shared by the freefall/motion event detector
package fme_pkg;

  // Register offsets on the register port
  localparam logic [7:0] FME_ADDR_CFG = 8'h15;
  localparam logic [7:0] FME_ADDR_SRC = 8'h16;
  localparam logic [7:0] FME_ADDR_THS = 8'h17;
  localparam logic [7:0] FME_ADDR_CNT = 8'h18;

  // Configuration register fields
  localparam int FME_CFG_LATCH = 7;
  localparam int FME_CFG_OR_AND = 6;
  localparam int FME_CFG_EN_HI = 5;
  localparam int FME_CFG_EN_LO = 3;
  localparam logic [7:0] FME_CFG_WMASK = 8'hF8;

  // Threshold register fields
  localparam int FME_THS_CLR_MODE = 7;
  localparam int FME_THS_HI = 6;

  // Source register fields
  localparam int FME_SRC_ACTIVE = 7;

  // Reset values
  localparam logic [7:0] FME_CFG_RST = 8'h00;
  localparam logic [7:0] FME_THS_RST = 8'h00;
  localparam logic [7:0] FME_CNT_RST = 8'h00;
  localparam logic [5:0] FME_FLAGS_RST = 6'h00;
  localparam logic [7:0] FME_RDATA_RST = 8'h00;
  localparam logic [7:0] FME_ZERO8 = 8'h00;
  localparam logic [7:0] FME_ONE8 = 8'h01;
  localparam logic [2:0] FME_NO_AXES = 3'h0;

  // Threshold weight: 63 milli-g per count, 0..127 counts
  localparam int FME_THS_MILLI_G_PER_LSB = 63;

  // One signed acceleration sample per axis, one count equals one threshold step
  typedef struct packed {
    logic [7:0] z;
    logic [7:0] y;
    logic [7:0] x;
  } fme_accel_t;

  // Register port request
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } fme_reg_req_t;

endpackage

// ### rtl/fme_axis_cmp.sv
// Per-axis magnitude comparison against the threshold
`timescale 1ns/10ps
`default_nettype none
module fme_axis_cmp (
  input wire logic [7:0] sample_in,
  input wire logic [6:0] threshold_in,
  output logic high_g_out,
  output logic negative_out
);
  logic [7:0] magnitude;

  // Two's complement magnitude; the most negative code maps to 128
  assign magnitude = sample_in[7] ? 8'((~sample_in) + 8'h01) : sample_in;
  assign high_g_out = magnitude > {1'b0, threshold_in};
  assign negative_out = sample_in[7];
endmodule
`default_nettype wire

// ### rtl/fme_detector.sv
// Freefall/motion event detector with debounce and source/config registers
`timescale 1ns/10ps
`default_nettype none
module fme_detector (
  input wire logic core_clk_in,
  input wire logic arst_n_in,
  input wire logic standby_in,
  input wire logic sample_valid_in,
  input wire fme_pkg::fme_accel_t accel_in,
  input wire fme_pkg::fme_reg_req_t reg_req_in,
  output logic [7:0] reg_rdata_out,
  output logic reg_rvalid_out,
  output logic event_active_out
);
  import fme_pkg::*;

  logic [7:0] event_config_register;
  logic [7:0] event_threshold_register;
  logic [7:0] event_debounce_count;
  logic [7:0] debounce_cnt;
  logic [7:0] next_debounce_cnt;
  logic [7:0] stepped_cnt;
  logic event_active_flag;
  logic next_event_active_flag;
  logic [5:0] axis_flags;
  logic [5:0] next_axis_flags;
  logic [5:0] live_flags;
  logic [2:0] axis_enable;
  logic [2:0] axis_high;
  logic [2:0] axis_neg;
  logic [2:0] enabled_high;
  logic event_latch_enable;
  logic or_and_select;
  logic debounce_clear_mode;
  logic detector_off;
  logic freefall_cond;
  logic motion_cond;
  logic cond;
  logic src_read;
  logic latched_read;
  logic event_set;
  logic event_lapse;
  logic [7:0] axis_samples [3];

  // Expands the three axis enables to the six bit positions of the flag pairs
  function automatic logic [5:0] pair_mask(input logic [2:0] en);
    pair_mask = {en[2], en[2], en[1], en[1], en[0], en[0]};
  endfunction

  // Source register image; flags of disabled axes read as zero
  function automatic logic [7:0] src_image(input logic active, input logic [5:0] flags,
                                           input logic [2:0] en);
    src_image = {active, 1'b0, flags & pair_mask(en)};
  endfunction

  assign event_latch_enable = event_config_register[FME_CFG_LATCH];
  assign or_and_select = event_config_register[FME_CFG_OR_AND];
  assign axis_enable = event_config_register[FME_CFG_EN_HI:FME_CFG_EN_LO];
  assign debounce_clear_mode = event_threshold_register[FME_THS_CLR_MODE];
  assign axis_samples[0] = accel_in.x;
  assign axis_samples[1] = accel_in.y;
  assign axis_samples[2] = accel_in.z;

  for (genvar i = 0; i < 3; i++) begin : g_axis
    fme_axis_cmp u_cmp (
      .sample_in(axis_samples[i]),
      .threshold_in(event_threshold_register[FME_THS_HI:0]),
      .high_g_out(axis_high[i]),
      .negative_out(axis_neg[i])
    );
  end

  assign enabled_high = axis_high & axis_enable;
  // all enables low disables the detector
  assign detector_off = standby_in || (axis_enable == FME_NO_AXES);
  // freefall: every enabled axis at or below threshold
  assign freefall_cond = (axis_enable != FME_NO_AXES) && (enabled_high == FME_NO_AXES);
  assign motion_cond = enabled_high != FME_NO_AXES;
  // select combines the axes by AND or OR
  assign cond = or_and_select ? motion_cond : freefall_cond;
  // live flags: high-g and its sign per axis
  assign live_flags = {enabled_high[2], enabled_high[2] & axis_neg[2],
                       enabled_high[1], enabled_high[1] & axis_neg[1],
                       enabled_high[0], enabled_high[0] & axis_neg[0]};

  assign src_read = reg_req_in.rd && (reg_req_in.addr == FME_ADDR_SRC);
  // only the latched modes give a source read a side effect
  assign latched_read = src_read && event_latch_enable;

  always_comb begin
    stepped_cnt = debounce_cnt;
    if (sample_valid_in) begin
      if (cond) begin
        if (debounce_cnt < event_debounce_count) begin
          stepped_cnt = 8'(debounce_cnt + FME_ONE8);
        end else begin
          stepped_cnt = event_debounce_count;
        end
      end else if (debounce_clear_mode) begin
        stepped_cnt = FME_ZERO8;
      end else if (debounce_cnt != FME_ZERO8) begin
        stepped_cnt = 8'(debounce_cnt - FME_ONE8);
      end
    end
  end

  // event only once the count is complete
  assign event_set = sample_valid_in && cond && (stepped_cnt >= event_debounce_count);
  // unlatched flag drops when the counter is back at zero
  assign event_lapse = sample_valid_in && !cond && (stepped_cnt == FME_ZERO8);

  always_comb begin
    next_debounce_cnt = stepped_cnt;
    if (detector_off) begin
      next_debounce_cnt = FME_ZERO8;
    // latched source read restarts the debounce
    end else if (latched_read && !event_set) begin
      next_debounce_cnt = FME_ZERO8;
    end
  end

  always_comb begin
    next_event_active_flag = event_active_flag;
    if (detector_off) begin
      next_event_active_flag = 1'b0;
    end else if (event_set) begin
      next_event_active_flag = 1'b1;
    // latched flag waits for the source read
    end else if (event_latch_enable) begin
      if (src_read) begin
        next_event_active_flag = 1'b0;
      end
    end else if (event_lapse) begin
      next_event_active_flag = 1'b0;
    end
  end

  always_comb begin
    next_axis_flags = axis_flags;
    if (standby_in) begin
      next_axis_flags = FME_FLAGS_RST;
    // latched motion read empties the source register
    end else if (latched_read && or_and_select && !event_set) begin
      next_axis_flags = FME_FLAGS_RST;
    // flags frozen while a latched event stands
    end else if (sample_valid_in && !(event_latch_enable && event_active_flag)) begin
      next_axis_flags = live_flags;
    end
  end

  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      debounce_cnt <= FME_CNT_RST;
    end else begin
      debounce_cnt <= next_debounce_cnt;
    end
  end

  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      event_active_flag <= 1'b0;
      event_active_out <= 1'b0;
    end else begin
      event_active_flag <= next_event_active_flag;
      event_active_out <= next_event_active_flag;
    end
  end

  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      axis_flags <= FME_FLAGS_RST;
    end else begin
      axis_flags <= next_axis_flags;
    end
  end

  // writable configuration, threshold and count registers
  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      event_config_register <= FME_CFG_RST;
      event_threshold_register <= FME_THS_RST;
      event_debounce_count <= FME_CNT_RST;
    end else if (reg_req_in.wr) begin
      case (reg_req_in.addr)
        FME_ADDR_CFG: event_config_register <= reg_req_in.wdata & FME_CFG_WMASK;
        FME_ADDR_THS: event_threshold_register <= reg_req_in.wdata;
        FME_ADDR_CNT: event_debounce_count <= reg_req_in.wdata;
        default: event_config_register <= event_config_register;
      endcase
    end
  end

  // read port; source register is read-only
  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      reg_rdata_out <= FME_RDATA_RST;
      reg_rvalid_out <= 1'b0;
    end else begin
      reg_rvalid_out <= reg_req_in.rd;
      if (reg_req_in.rd) begin
        case (reg_req_in.addr)
          FME_ADDR_CFG: reg_rdata_out <= event_config_register;
          FME_ADDR_SRC: reg_rdata_out <= src_image(event_active_flag, axis_flags, axis_enable);
          FME_ADDR_THS: reg_rdata_out <= event_threshold_register;
          FME_ADDR_CNT: reg_rdata_out <= event_debounce_count;
          default: reg_rdata_out <= FME_ZERO8;
        endcase
      end
    end
  end

  sequence s_latched_read;
    event_latch_enable && src_read && !event_set && !standby_in;
  endsequence

  sequence s_cleared;
    !event_active_flag && (debounce_cnt == FME_ZERO8);
  endsequence

  property p_read_clears;
    @(posedge core_clk_in) disable iff (!arst_n_in)
      s_latched_read |=> s_cleared;
  endproperty

  chk_disabled_no_event: assert property (
    @(posedge core_clk_in) disable iff (!arst_n_in)
      (axis_enable == FME_NO_AXES) |=> !event_active_flag && !event_active_out)
    else $error("event raised with all axes disabled");

  chk_complete_sets_event: assert property (
    @(posedge core_clk_in) disable iff (!arst_n_in)
      (sample_valid_in && cond && !detector_off
       && debounce_cnt >= event_debounce_count) |=> event_active_flag)
    else $error("event not raised after debounce completed");

  chk_unlatched_read_keep: assert property (
    @(posedge core_clk_in) disable iff (!arst_n_in)
      (!event_latch_enable && src_read && !sample_valid_in && !detector_off)
      |=> $stable(event_active_flag) && $stable(debounce_cnt) && $stable(axis_flags))
    else $error("unlatched source read changed detector state");

  chk_latched_read_clear: assert property (p_read_clears)
    else $error("latched source read did not clear flag and counter");

  chk_latched_hold: assert property (
    @(posedge core_clk_in) disable iff (!arst_n_in)
      (event_latch_enable && event_active_flag && !src_read && !detector_off)
      |=> event_active_flag)
    else $error("latched event flag dropped without a read");

  chk_flags_frozen: assert property (
    @(posedge core_clk_in) disable iff (!arst_n_in)
      (event_latch_enable && event_active_flag && !src_read && !standby_in)
      |=> $stable(axis_flags))
    else $error("axis flags moved while latched event stands");

  chk_clear_mode_drop: assert property (
    @(posedge core_clk_in) disable iff (!arst_n_in)
      (!event_latch_enable && debounce_clear_mode && sample_valid_in && !cond)
      |=> !event_active_flag && (debounce_cnt == FME_ZERO8))
    else $error("clear mode did not drop the event at once");

  chk_decrement_step: assert property (
    @(posedge core_clk_in) disable iff (!arst_n_in)
      (!event_latch_enable && !debounce_clear_mode && sample_valid_in && !cond
       && debounce_cnt > FME_ONE8 && !detector_off)
      |=> (debounce_cnt == 8'($past(debounce_cnt) - FME_ONE8))
          && $stable(event_active_flag))
    else $error("decrement mode did not step down by one");

  chk_live_flags: assert property (
    @(posedge core_clk_in) disable iff (!arst_n_in)
      (!event_latch_enable && sample_valid_in && !standby_in)
      |=> axis_flags == $past(live_flags))
    else $error("unlatched axis flags not following live status");

  chk_count_advance: assert property (
    @(posedge core_clk_in) disable iff (!arst_n_in)
      (sample_valid_in && cond && debounce_cnt < event_debounce_count
       && !detector_off && !latched_read)
      |=> debounce_cnt == 8'($past(debounce_cnt) + FME_ONE8))
    else $error("debounce counter did not advance on a sample");

  // Last decrement of an unlatched debounce run
  sequence s_last_decrement;
    !event_latch_enable && !debounce_clear_mode && sample_valid_in && !cond
    && !detector_off && (debounce_cnt == FME_ONE8);
  endsequence

  // First qualifying sample after a clear-mode drop
  sequence s_rearm_start;
    !event_latch_enable && debounce_clear_mode && sample_valid_in && cond
    && !detector_off && !event_active_flag && (debounce_cnt == FME_ZERO8)
    && (event_debounce_count > FME_ONE8);
  endsequence

  chk_decrement_drop: assert property (
    @(posedge core_clk_in) disable iff (!arst_n_in)
      s_last_decrement |=> !event_active_flag && (debounce_cnt == FME_ZERO8))
    else $error("decrement mode did not drop the event at zero");

  chk_clear_rearm: assert property (
    @(posedge core_clk_in) disable iff (!arst_n_in)
      s_rearm_start |=> !event_active_flag && (debounce_cnt == FME_ONE8))
    else $error("event came back before the full delay");

  chk_motion_read_empty: assert property (
    @(posedge core_clk_in) disable iff (!arst_n_in)
      (event_latch_enable && or_and_select && src_read && !event_set && !standby_in)
      |=> (axis_flags == FME_FLAGS_RST))
    else $error("latched motion read left axis flags set");

  chk_src_write_ignored: assert property (
    @(posedge core_clk_in) disable iff (!arst_n_in)
      (reg_req_in.wr && (reg_req_in.addr == FME_ADDR_SRC))
      |=> $stable(event_config_register) && $stable(event_threshold_register)
          && $stable(event_debounce_count))
    else $error("write to the source register changed a register");

  chk_cfg_low_bits: assert property (
    @(posedge core_clk_in) disable iff (!arst_n_in)
      (reg_req_in.wr && (reg_req_in.addr == FME_ADDR_CFG))
      |=> ((event_config_register & ~FME_CFG_WMASK) == FME_ZERO8))
    else $error("configuration low bits not zero");

  chk_source_image: assert property (
    @(posedge core_clk_in) disable iff (!arst_n_in)
      src_read |=> reg_rvalid_out && (reg_rdata_out[FME_SRC_ACTIVE] == $past(event_active_flag))
                   && (reg_rdata_out[FME_SRC_ACTIVE - 1] == 1'b0))
    else $error("source read data wrong in event or zero bit");

  chk_motion_any_axis: assert property (
    @(posedge core_clk_in) disable iff (!arst_n_in)
      (sample_valid_in && or_and_select && !detector_off && (enabled_high != FME_NO_AXES)
       && (event_debounce_count == FME_ZERO8))
      |=> event_active_flag)
    else $error("motion on one enabled axis raised no event");

endmodule
`default_nettype wire
